/* src/bus_driver_mode_wakeup.sv */
/*
 * Digital core of a single channel bus transceiver: mode control, transmitter
 * symbol selection, transmit enable timeout, receive output and remote wakeup.
 * Assumes pins arrive asynchronously, an analog front end decodes and drives the
 * bus symbols, and software reaches the registers over APB on the same clock.
 */
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module bus_driver_mode_wakeup
    import bus_driver_pkg::*;
#(
    parameter int TX_TIMEOUT_CYCLES = TX_ACTIVE_MAX_CYCLES
)
(
    input  wire logic          clk,
    input  wire logic          srst,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          standbyControlN,
    input  wire logic          transmitEnableN,
    input  wire logic          guardianEnable,
    input  wire logic          transmitData,
    input  wire logic [1:0]    busRxLevel,
    input  wire logic          ioUnderVoltage,
    input  wire logic          mainUnderVoltage,
    input  wire logic          mainSupplyOk,
    output busSymbol_type      busTxSymbol,
    output logic               receiveDataOut,
    output logic               fullSpeedRxEn,
    output logic               lowPowerRxEn,
    output logic               normalMode,
    output logic               irq
);
    localparam logic [TMO_W-1:0] TMO_LIM = TMO_W'(TX_TIMEOUT_CYCLES);

    logic [8:0]         syncA_r;
    logic [8:0]         syncB_r;
    logic               stbnS;
    logic               teNS;
    logic               guardS;
    logic               txdS;
    busSymbol_type      busS;
    logic               uvIoS;
    logic               uvMainS;
    logic               vccOkS;
    logic               uvIoPrev_r;
    logic               uvMainPrev_r;
    logic               uvIoRise;
    logic               uvMainRise;
    logic               uvIoFlag_r;
    logic               uvMainFlag_r;
    logic               uvForce;
    mode_type           mode_r;
    mode_type           mode_nxt;
    logic               wakeHold_r;
    logic               wakeFlag_r;
    logic               wakeSeen;
    logic               wakeEvt;
    logic               teNPrev_r;
    logic               teFall;
    logic               txArmed_r;
    logic               txStarted_r;
    logic               lowCond;
    logic [TMO_W-1:0]   tmoCnt_r;
    logic               tmoEvt;
    logic               tmoLock_r;
    busSymbol_type      busTx_nxt;
    logic [EV_W-1:0]    status_r;
    logic [EV_W-1:0]    mask_r;
    logic               ctrlWakeEn_r;
    logic [EV_W-1:0]    events;
    logic [EV_W-1:0]    clearBits;
    logic               wrAccess;
    logic [31:0]        readWord;
    logic [TMO_W:0]     lowRun_r;

    function automatic logic addrHit(input logic [7:0] a);
        addrHit = (a == ADDR_STATUS) || (a == ADDR_MASK) || (a == ADDR_STATE)
                  || (a == ADDR_CTRL);
    endfunction : addrHit

    // Two stage synchroniser for every pin; only the second stage is read
    always_ff @(posedge clk) begin
        if (srst) begin
            syncA_r <= SYNC_RST;
            syncB_r <= SYNC_RST;
        end else begin
            syncA_r <= {mainSupplyOk, mainUnderVoltage, ioUnderVoltage, busRxLevel,
                        transmitData, guardianEnable, transmitEnableN, standbyControlN};
            syncB_r <= syncA_r;
        end
    end

    assign stbnS   = syncB_r[0];
    assign teNS    = syncB_r[1];
    assign guardS  = syncB_r[2];
    assign txdS    = syncB_r[3];
    assign busS    = busSymbol_type'(syncB_r[5:4]);
    assign uvIoS   = syncB_r[6];
    assign uvMainS = syncB_r[7];
    assign vccOkS  = syncB_r[8];

    // Edge history of synchronised levels
    always_ff @(posedge clk) begin
        if (srst) begin
            uvIoPrev_r   <= 1'b0;
            uvMainPrev_r <= 1'b0;
            teNPrev_r    <= 1'b1;
        end else begin
            uvIoPrev_r   <= uvIoS;
            uvMainPrev_r <= uvMainS;
            teNPrev_r    <= teNS;
        end
    end

    assign uvIoRise   = uvIoS && !uvIoPrev_r;
    assign uvMainRise = uvMainS && !uvMainPrev_r;
    assign teFall     = teNPrev_r && !teNS;

    // Under-voltage flags: set on onset, dropped on recovery or by a wake
    always_ff @(posedge clk) begin
        if (srst) begin
            uvIoFlag_r   <= 1'b0;
            uvMainFlag_r <= 1'b0;
        end else if (wakeEvt) begin
            // A wake clears the flags, but an onset in the same cycle still sets
            uvIoFlag_r   <= uvIoRise;
            uvMainFlag_r <= uvMainRise;
        end else begin
            uvIoFlag_r   <= uvIoRise || (uvIoFlag_r && uvIoS);
            uvMainFlag_r <= uvMainRise || (uvMainFlag_r && uvMainS);
        end
    end

    // Flag onset acts at once, so the mode never lags the flag by a cycle
    assign uvForce = uvIoFlag_r || uvMainFlag_r || uvIoRise || uvMainRise;

    // Mode selection
    always_comb begin
        mode_nxt = mode_r;
        if (uvForce) begin
            mode_nxt = MODE_STANDBY;
        end else begin
            case (mode_r)
                MODE_STANDBY: if (stbnS && !wakeHold_r && !wakeEvt) mode_nxt = MODE_NORMAL;
                MODE_NORMAL:  if (!stbnS) mode_nxt = MODE_STANDBY;
                default:      mode_nxt = MODE_STANDBY;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) mode_r <= MODE_STANDBY;
        else      mode_r <= mode_nxt;
    end

    // A wake parks the device in Standby until the control input is cycled
    always_ff @(posedge clk) begin
        if (srst)          wakeHold_r <= 1'b0;
        else if (wakeEvt)  wakeHold_r <= 1'b1;
        else if (!stbnS)   wakeHold_r <= 1'b0;
    end

    // Detector runs in both modes so a pattern may straddle the mode change
    wake_detect u_wake (
        .clk      (clk),
        .srst     (srst),
        .enable   (ctrlWakeEn_r && vccOkS),
        .busLevel (busS),
        .wakeSeen (wakeSeen)
    );

    // One wake treatment whatever the source
    assign wakeEvt = wakeSeen && (mode_r == MODE_STANDBY) && vccOkS;

    // Wake flag; a fresh wake beats the clear on entering Normal
    always_ff @(posedge clk) begin
        if (srst)                          wakeFlag_r <= 1'b0;
        else if (wakeEvt)                  wakeFlag_r <= 1'b1;
        else if (mode_nxt == MODE_NORMAL)  wakeFlag_r <= 1'b0;
    end

    // Activation must begin with a falling enable while already Normal
    always_ff @(posedge clk) begin
        if (srst) begin
            txArmed_r <= 1'b0;
        end else if (mode_r != MODE_NORMAL || teNS || tmoEvt) begin
            txArmed_r <= 1'b0;
        end else if (teFall && !tmoLock_r) begin
            txArmed_r <= 1'b1;
        end
    end

    // First driven symbol of an activation is a dominant zero; a guardian veto
    // ends the transmission, so driving resumes only with a fresh dominant zero
    always_ff @(posedge clk) begin
        if (srst)                       txStarted_r <= 1'b0;
        else if (!txArmed_r || !guardS) txStarted_r <= 1'b0;
        else if (!txdS)             txStarted_r <= 1'b1;
    end

    // Timeout counter: counts enable-low cycles in Normal and saturates at the limit
    assign lowCond = (mode_r == MODE_NORMAL) && !teNS;
    assign tmoEvt  = lowCond && (tmoCnt_r == TMO_LIM) && !tmoLock_r;

    always_ff @(posedge clk) begin
        if (srst)                    tmoCnt_r <= '0;
        else if (!lowCond)           tmoCnt_r <= '0;
        else if (tmoCnt_r != TMO_LIM) tmoCnt_r <= tmoCnt_r + 1'b1;
    end

    // Lock holds the transmitter off until the enable is released
    always_ff @(posedge clk) begin
        if (srst)        tmoLock_r <= 1'b0;
        else if (tmoEvt) tmoLock_r <= 1'b1;
        else if (teNS)   tmoLock_r <= 1'b0;
    end

    // Transmitted symbol selection
    always_comb begin
        busTx_nxt = SYM_IDLE;
        if (mode_r == MODE_STANDBY) begin
            busTx_nxt = SYM_LP_IDLE;
        end else if (!guardS || teNS) begin
            busTx_nxt = SYM_IDLE;
        end else if (txArmed_r && !tmoLock_r && (txStarted_r || !txdS)) begin
            busTx_nxt = txdS ? SYM_ONE : SYM_ZERO;
        end
    end

    // Bus and receive outputs from flops
    always_ff @(posedge clk) begin
        if (srst) begin
            busTxSymbol    <= SYM_LP_IDLE;
            receiveDataOut <= 1'b1;
        end else begin
            busTxSymbol    <= busTx_nxt;
            if (mode_r == MODE_STANDBY) receiveDataOut <= !wakeFlag_r;
            else                        receiveDataOut <= (busS != SYM_ZERO);
        end
    end

    // Receiver selection follows the mode flop directly
    assign fullSpeedRxEn = (mode_r == MODE_NORMAL);
    assign lowPowerRxEn  = (mode_r == MODE_STANDBY);
    assign normalMode    = (mode_r == MODE_NORMAL);

    // APB slave: zero wait states, error on unmapped offsets
    assign pready    = 1'b1;
    assign pslverr   = psel && penable && !addrHit(paddr);
    assign wrAccess  = psel && penable && pwrite && addrHit(paddr);
    assign clearBits = (wrAccess && paddr == ADDR_STATUS) ? pwdata[EV_W-1:0] : '0;
    assign events    = {uvMainRise, uvIoRise, tmoEvt, wakeEvt};

    // Sticky status, write one to clear; a same-cycle event wins
    always_ff @(posedge clk) begin
        if (srst) status_r <= '0;
        else      status_r <= (status_r & ~clearBits) | events;
    end

    // Software writable registers
    always_ff @(posedge clk) begin
        if (srst) begin
            mask_r       <= MASK_RST;
            ctrlWakeEn_r <= CTRL_RST;
        end else if (wrAccess) begin
            if (paddr == ADDR_MASK) mask_r       <= pwdata[EV_W-1:0];
            if (paddr == ADDR_CTRL) ctrlWakeEn_r <= pwdata[CTRL_WAKE_EN];
        end
    end

    // Read mux; unused upper bits read as zero
    always_comb begin
        readWord = 32'h0000_0000;
        case (paddr)
            ADDR_STATUS: readWord[EV_W-1:0] = status_r;
            ADDR_MASK:   readWord[EV_W-1:0] = mask_r;
            ADDR_STATE: begin
                readWord[SS_NORMAL] = (mode_r == MODE_NORMAL);
                readWord[SS_TXON]   = (busTxSymbol == SYM_ZERO) || (busTxSymbol == SYM_ONE);
                readWord[SS_WAKE]   = wakeFlag_r;
                readWord[SS_GUARD]  = guardS && (mode_r == MODE_NORMAL);
            end
            ADDR_CTRL:   readWord[CTRL_WAKE_EN] = ctrlWakeEn_r;
            default:     readWord = 32'h0000_0000;
        endcase
    end

    // Captured in setup so the access phase sees stable data
    always_ff @(posedge clk) begin
        if (srst)                   prdata <= 32'h0000_0000;
        else if (psel && !penable)  prdata <= readWord;
    end

    assign irq = |(status_r & mask_r);

    // Helper: independent count of enable-low cycles in Normal
    always_ff @(posedge clk) begin
        if (srst || !lowCond)  lowRun_r <= '0;
        else if (!(&lowRun_r)) lowRun_r <= lowRun_r + 1'b1;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // Rule checks on the design's own state
    a_uv_forces_standby: assert property ((uvIoRise || uvMainRise) |=>
        mode_r == MODE_STANDBY [*2]) else $error("under-voltage did not force standby");
    a_recovery_gives_ctrl: assert property ((!uvForce && !wakeHold_r && !wakeEvt
        && stbnS && mode_r == MODE_STANDBY) |=> mode_r == MODE_NORMAL)
        else $error("recovered device ignored standby control");
    a_wake_clears_uv: assert property (wakeEvt |=> uvIoFlag_r == $past(uvIoRise)
        && uvMainFlag_r == $past(uvMainRise) && mode_r == MODE_STANDBY)
        else $error("wake left under-voltage or mode");
    a_start_with_zero: assert property (busTxSymbol == SYM_ONE |->
        $past(busTxSymbol) inside {SYM_ZERO, SYM_ONE}) else $error("transmission began with one");
    a_timeout_disables: assert property (tmoEvt |-> ##2
        !(busTxSymbol inside {SYM_ZERO, SYM_ONE}) && status_r[ST_TMO])
        else $error("timeout did not stop transmitter");
    a_timeout_length: assert property (tmoEvt |-> lowRun_r == {1'b0, TMO_LIM}
        && $past(lowCond)) else $error("timeout at wrong cycle count");
    a_lock_holds_off: assert property (tmoLock_r |=>
        !(busTxSymbol inside {SYM_ZERO, SYM_ONE})) else $error("transmitter on during lock");
    a_tx_needs_arm: assert property ((busTx_nxt inside {SYM_ZERO, SYM_ONE}) |->
        txArmed_r && mode_r == MODE_NORMAL) else $error("transmitter on without activation");
    a_rx_select: assert property ($changed(mode_r) |-> fullSpeedRxEn != lowPowerRxEn
        && fullSpeedRxEn == $past(mode_nxt == MODE_NORMAL)) else $error("receiver select wrong");
    a_standby_lp_idle: assert property (mode_r == MODE_STANDBY |=>
        busTxSymbol == SYM_LP_IDLE) else $error("standby bus not low-power idle");
    a_guardian_idle: assert property ((mode_r == MODE_NORMAL && !guardS) |=>
        busTxSymbol == SYM_IDLE) else $error("guardian low but bus driven");
    a_rxd_wake: assert property ((mode_r == MODE_STANDBY && wakeFlag_r) |=>
        !receiveDataOut) else $error("receive output high with wake flag");
    a_wake_signal: assert property (wakeEvt |=> wakeFlag_r && status_r[ST_WAKE]
        && wakeHold_r) else $error("wake not signalled");

    // Main scenarios reached
    c_wake:    cover property (wakeEvt ##1 !receiveDataOut);
    c_timeout: cover property (tmoEvt ##1 tmoLock_r);
    c_tx_zero: cover property (busTxSymbol == SYM_ZERO ##1 busTxSymbol == SYM_ONE);
    c_normal:  cover property ($rose(normalMode));
    c_uv_force: cover property ($rose(uvIoFlag_r) ##1 lowPowerRxEn);

endmodule : bus_driver_mode_wakeup

/* src/bus_driver_pkg.sv */
/*
 * Shared constants and types for the bus driver mode, transmit and wakeup logic.
 * Assumes one 100 MHz clock and an analog front end that turns bus_plus and
 * bus_minus into a decoded symbol and drives the bus from a requested symbol.
 */
package bus_driver_pkg;

    // Clock and timing
    localparam int CLK_PERIOD_NS        = 10;
    localparam int TX_ACTIVE_MAX_NS     = 1500000;
    localparam int TX_ACTIVE_MAX_CYCLES = TX_ACTIVE_MAX_NS / CLK_PERIOD_NS;
    localparam int TMO_W                = 18;
    localparam int WAKE_ZERO_MIN_NS     = 1000;
    localparam int WAKE_SEP_MIN_NS      = 1000;
    localparam int WAKE_SEP_MAX_NS      = 20000;
    localparam int WAKE_ZERO_MIN_CYCLES = (WAKE_ZERO_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_SEP_MIN_CYCLES  = (WAKE_SEP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_SEP_MAX_CYCLES  = WAKE_SEP_MAX_NS / CLK_PERIOD_NS;
    localparam int RUN_W                = 12;

    // Register byte offsets
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_MASK   = 8'h04;
    localparam logic [7:0] ADDR_STATE  = 8'h08;
    localparam logic [7:0] ADDR_CTRL   = 8'h0C;

    // Status and mask layout
    localparam int EV_W      = 4;
    localparam int ST_WAKE   = 0;
    localparam int ST_TMO    = 1;
    localparam int ST_UVIO   = 2;
    localparam int ST_UVMAIN = 3;

    // State register layout
    localparam int SS_NORMAL = 0;
    localparam int SS_TXON   = 1;
    localparam int SS_WAKE   = 2;
    localparam int SS_GUARD  = 3;

    // Control layout and reset values
    localparam int               CTRL_WAKE_EN = 0;
    localparam logic             CTRL_RST     = 1'b1;
    localparam logic [EV_W-1:0]  MASK_RST     = 4'h0;
    localparam logic [8:0]       SYNC_RST     = 9'h002;

    typedef enum logic [1:0] {SYM_IDLE, SYM_ZERO, SYM_ONE, SYM_LP_IDLE} busSymbol_type;
    typedef enum logic {MODE_STANDBY, MODE_NORMAL} mode_type;

endpackage : bus_driver_pkg

/* src/wake_detect.sv */
/*
 * Remote wakeup detector: two dominant zero runs split by an idle or dominant one run.
 * Assumes a synchronised decoded bus symbol on the same clock.
 */
`timescale 1ns/10ps
module wake_detect
    import bus_driver_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          srst,
    input  wire logic          enable,
    input  busSymbol_type      busLevel,
    output logic               wakeSeen
);
    typedef enum logic [1:0] {WD_WAIT, WD_ZERO1, WD_SEP, WD_ZERO2} wdState_type;

    localparam logic [RUN_W-1:0] ZMIN = RUN_W'(WAKE_ZERO_MIN_CYCLES);
    localparam logic [RUN_W-1:0] SMIN = RUN_W'(WAKE_SEP_MIN_CYCLES);
    localparam logic [RUN_W-1:0] SMAX = RUN_W'(WAKE_SEP_MAX_CYCLES);

    wdState_type      state_r;
    logic [RUN_W-1:0] run_r;
    logic             isZero;

    function automatic logic [RUN_W-1:0] satInc(input logic [RUN_W-1:0] v);
        satInc = (&v) ? v : v + 1'b1;
    endfunction : satInc

    assign isZero = (busLevel == SYM_ZERO);

    // Run tracker; frame byte runs of 0x00 and 0xFF look like the alternative pattern
    always_ff @(posedge clk) begin
        wakeSeen <= 1'b0;
        if (srst || !enable) begin
            state_r <= WD_WAIT;
            run_r   <= '0;
        end else begin
            run_r <= satInc(run_r);
            case (state_r)
                WD_WAIT: begin
                    run_r <= 12'h001;
                    if (isZero) state_r <= WD_ZERO1;
                end
                WD_ZERO1: if (!isZero) begin
                    run_r   <= 12'h001;
                    state_r <= (run_r >= ZMIN) ? WD_SEP : WD_WAIT;
                end
                WD_SEP: if (isZero) begin
                    run_r   <= 12'h001;
                    state_r <= (run_r >= SMIN) ? WD_ZERO2 : WD_ZERO1;
                end else if (run_r > SMAX) begin
                    state_r <= WD_WAIT; // Long silence ends a half pattern
                end
                WD_ZERO2: if (!isZero) begin
                    state_r <= WD_WAIT;
                end else if (run_r == ZMIN - 1'b1) begin
                    wakeSeen <= 1'b1;
                    state_r  <= WD_WAIT;
                end
                default: state_r <= WD_WAIT;
            endcase
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_pulse_after_zero2: assert property (wakeSeen |-> $past(state_r) == WD_ZERO2
        && $past(isZero)) else $error("wake pulse without second zero run");

endmodule : wake_detect

/* tb/bus_partner.sv */
/*
 * Far-side model: the bus wire with a remote node, plus the bus guardian.
 * Assumes the front end decodes onto busRxLevel what is on the wire.
 */
`timescale 1ns/10ps
module bus_partner
    import bus_driver_pkg::*;
(
    input  wire logic          clk,
    input  busSymbol_type      busTxSymbol,
    input  wire logic          remoteOn,
    input  busSymbol_type      remoteSym,
    input  wire logic          guardOk,
    output logic [1:0]         busRxLevel,
    output logic               guardianEnable
);
    // Remote node owns the wire when active, else we hear our own driver
    initial busRxLevel = 2'd0;
    always @(posedge clk) begin
        busRxLevel <= remoteOn ? remoteSym : busTxSymbol;
    end
    // Guardian may veto transmission at any time
    assign guardianEnable = guardOk;
endmodule : bus_partner

/* tb/tb_bus_driver_mode_wakeup.sv */
/*
 * Testbench: APB master, pin driver, queued result checker.
 * Assumes the design package and bus_partner as the far side.
 */
`timescale 1ns/10ps
`define CK(n, e, o) begin n_tests++; if ((o) !== (e)) begin errors++; \
    $display("[FAIL] %s exp %h got %h", n, e, o); end end
module tb_bus_driver_mode_wakeup;
    import bus_driver_pkg::*;
    logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, err;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, rnd = 32'd21;
    logic pready, pslverr, stbyN = 0, teN = 1, txd = 0, ioUv = 0, mainUv = 0, supOk = 1;
    logic remOn = 0, guardOk = 1, rxd, fsRx, lpRx, normal, irq, guard;
    logic [1:0] rxLvl;
    logic [32:0] qe[$];
    busSymbol_type txSym, remSym = SYM_IDLE;
    int errors = 0, n_tests = 0, cyc = 0, qk[$];

    bus_driver_mode_wakeup #(.TX_TIMEOUT_CYCLES(50)) u_bus_driver_mode_wakeup (
        .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .standbyControlN(stbyN), .transmitEnableN(teN),
        .guardianEnable(guard), .transmitData(txd), .busRxLevel(rxLvl),
        .ioUnderVoltage(ioUv), .mainUnderVoltage(mainUv), .mainSupplyOk(supOk),
        .busTxSymbol(txSym), .receiveDataOut(rxd), .fullSpeedRxEn(fsRx),
        .lowPowerRxEn(lpRx), .normalMode(normal), .irq(irq));
    bus_partner u_bus_partner (.clk(clk), .busTxSymbol(txSym), .remoteOn(remOn),
        .remoteSym(remSym), .guardOk(guardOk), .busRxLevel(rxLvl),
        .guardianEnable(guard));

    always #5 clk = ~clk;
    // Hang guard; the full run needs about 2000 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            errors++;
            end_sim();
        end
    end
    task automatic end_sim();
        if (errors == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_sim
    // Watcher: oldest note against the outputs it names
    always @(negedge clk) begin
        if (qk.size() > 0) begin
            if (qk[0] == 0) `CK("pins", qe[0], {26'd0, irq, normal, fsRx, lpRx, txSym, rxd})
            else `CK("apb", qe[0], {err, rd})
            void'(qk.pop_front());
            void'(qe.pop_front());
        end
    end
    function automatic logic [31:0] xs(logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction : xs
    task automatic w(int n);
        repeat (n) @(posedge clk);
    endtask : w
    // Receiver enables always mirror the mode, so they ride in every note
    task automatic pin(logic i, logic n, busSymbol_type s, logic x);
        qk.push_back(0);
        qe.push_back({26'd0, i, n, n, ~n, s, x});
        @(negedge clk);
        @(posedge clk);
    endtask : pin
    // Request held until pready is seen high at a rising edge
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task automatic rdck(logic [7:0] a, logic [32:0] e);
        apb(0, a, 0);
        qk.push_back(1);
        qe.push_back(e);
        @(negedge clk);
        @(posedge clk);
    endtask : rdck
    // Remote pattern; the device drops to Standby during the separator
    task automatic pattern(busSymbol_type sep);
        remOn <= 1; remSym <= SYM_ZERO; w(120);
        remSym <= sep; stbyN <= 0; w(120);
        remSym <= SYM_ZERO; w(120);
        remSym <= SYM_LP_IDLE; w(10);
    endtask : pattern

    initial begin
        w(20);
        srst <= 0;
        pin(0, 0, SYM_LP_IDLE, 1);
        rdck(ADDR_MASK, 33'd0);
        rdck(8'h10, {1'b1, 32'd0});
        rdck(ADDR_CTRL, 33'd1);
        apb(1, ADDR_MASK, 32'h0000_000f);
        // Enable already low on entry to Normal must not transmit
        @(posedge clk) begin stbyN <= 1; teN <= 0; end
        w(6); pin(0, 1, SYM_IDLE, 1);
        @(posedge clk) begin teN <= 1; txd <= 1; end
        w(4); teN <= 0;
        w(5); pin(0, 1, SYM_IDLE, 1);
        for (int i = 0; i < 4; i++) begin
            rnd = xs(rnd);
            txd <= rnd[0] & (i != 0);
            w(8); pin(0, 1, txd ? SYM_ONE : SYM_ZERO, txd);
        end
        @(posedge clk) begin teN <= 1; txd <= 0; guardOk <= 0; end
        w(4); teN <= 0;
        w(5); pin(0, 1, SYM_IDLE, 1);
        guardOk <= 1;
        w(8); pin(0, 1, SYM_ZERO, 0);
        w(60); pin(1, 1, SYM_IDLE, 1);
        rdck(ADDR_STATUS, 33'h0_0000_0002);
        apb(1, ADDR_STATUS, 32'h0000_0002);
        w(2); pin(0, 1, SYM_IDLE, 1);
        teN <= 1;
        w(4); teN <= 0;
        w(8); pin(0, 1, SYM_ZERO, 0);
        teN <= 1; ioUv <= 1;
        w(5); pin(1, 0, SYM_LP_IDLE, 1);
        ioUv <= 0;
        w(5); pin(1, 1, SYM_IDLE, 1);
        // Basic, alternative, no main supply, then detector switched off
        for (int k = 0; k < 4; k++) begin
            stbyN <= 1; supOk <= (k != 2);
            w(6); apb(1, ADDR_STATUS, 32'h0000_000f);
            if (k == 3) begin
                apb(1, ADDR_CTRL, 32'h0000_0000);
                rdck(ADDR_CTRL, 33'd0);
            end
            pattern(k == 1 ? SYM_ONE : SYM_IDLE);
            pin(k < 2, 0, SYM_LP_IDLE, k >= 2);
            if (k < 2) rdck(ADDR_STATE, 33'h0_0000_0004);
        end
        end_sim();
    end
endmodule : tb_bus_driver_mode_wakeup
